// >>> core/pslp_host.sv
// host controller that loads and uses the memory's low-power configuration
`timescale 1ns/1ps
`default_nettype none
// Contract
// - host writes zeros to reserved word bits
// - deep sleep changed only by pin load
// - wait 150us after deep sleep exit
// - threshold at or above case temperature
// - request held low over 10us to sleep
// - pin load latches address lines on write
// - software access: two reads, two top accesses
module pslp_host
  import pslp_pkg::*;
#(
  parameter int DPD_INIT_CYCLES = DPD_INIT_CYC
)
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire pslp_cmd_t cmd_i,
  input wire logic [1:0] temp_floor_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic error_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic [ADDR_W-1:0] cfg_shadow_o,
  output logic sw_loaded_o,
  output logic sleeping_o,
  output logic lp_req_n_o,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o
);
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ZZWE = 3'h1,
    S_PWR = 3'h2,
    S_SEQ = 3'h3,
    S_HOLD = 3'h4,
    S_SLEEP = 3'h5,
    S_INIT = 3'h6
  } pslp_st_t;

  pslp_st_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [1:0] step_r, step_nxt;
  logic seq_wr_r, seq_wr_nxt;
  logic [19:0] word_r, word_nxt, shadow_r, shadow_nxt;
  logic sw_loaded_r, sw_loaded_nxt, sleeping_r, sleeping_nxt;
  logic lp_n_r, lp_n_nxt, ready_r, ready_nxt, done_r, done_nxt;
  logic error_r, error_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic acc_start, acc_write, acc_done;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata, acc_rdata;
  logic take, temp_bad;
  logic [19:0] cmd_word;

  assign take = cmd_valid_i & ready_r;
  assign cmd_word = pslp_pack(cmd_i.cfg);
  assign temp_bad =
    pslp_temp_rank(cmd_i.cfg.temp_sel) < pslp_temp_rank(temp_floor_i);

  // ------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    seq_wr_nxt = seq_wr_r;
    word_nxt = word_r;
    shadow_nxt = shadow_r;
    sw_loaded_nxt = sw_loaded_r;
    sleeping_nxt = sleeping_r;
    lp_n_nxt = lp_n_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    error_nxt = 1'b0;
    acc_start = 1'b0;
    acc_write = 1'b0;
    acc_addr = CFG_TOP_ADDR;
    acc_wdata = 16'h0000;
    case (state_r)
      S_IDLE: begin
        if (take) begin
          case (cmd_i.op)
            OP_PIN_LOAD: begin
              if (temp_bad) begin
                error_nxt = 1'b1;
              end else begin
                word_nxt = cmd_word;
                lp_n_nxt = 1'b0;
                cnt_nxt = CNT_W'(ZZWE_CYC - 1);
                state_nxt = S_ZZWE;
              end
            end
            OP_SW_WRITE, OP_SW_READ: begin
              // deep sleep selection only goes through the pin load
              if (cmd_i.op == OP_SW_WRITE &&
                  (temp_bad || !cmd_i.cfg.sleep_sel)) begin
                error_nxt = 1'b1;
              end else begin
                word_nxt = cmd_word;
                seq_wr_nxt = (cmd_i.op == OP_SW_WRITE);
                step_nxt = 2'h0;
                acc_start = 1'b1;
                state_nxt = S_SEQ;
              end
            end
            OP_SLEEP: begin
              lp_n_nxt = 1'b0;
              cnt_nxt = CNT_W'(ZZ_HOLD_CYC - 1);
              state_nxt = S_HOLD;
            end
            default: done_nxt = 1'b1;
          endcase
        end
      end
      S_ZZWE: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end else begin
          acc_start = 1'b1;
          acc_write = 1'b1;
          acc_addr = word_r;
          state_nxt = S_PWR;
        end
      end
      S_PWR: begin
        acc_write = 1'b1;
        acc_addr = word_r;
        if (acc_done) begin
          lp_n_nxt = 1'b1;
          shadow_nxt = word_r;
          done_nxt = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      S_SEQ: begin
        // reads on steps 0 and 1, write on 2, step 3 per direction
        acc_write = step_r[1] & (seq_wr_r | ~step_r[0]);
        acc_wdata = seq_wr_r ? word_r[15:0] : 16'h0000;
        if (acc_done) begin
          if (step_r == 2'h3) begin
            if (seq_wr_r) begin
              shadow_nxt = word_r;
              sw_loaded_nxt = 1'b1;
            end else begin
              rdata_nxt = acc_rdata;
            end
            done_nxt = 1'b1;
            state_nxt = S_IDLE;
          end else begin
            step_nxt = step_r + 2'h1;
            acc_start = 1'b1;
            acc_write = step_nxt[1] & (seq_wr_r | ~step_nxt[0]);
          end
        end
      end
      S_HOLD: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end else begin
          sleeping_nxt = 1'b1;
          done_nxt = 1'b1;
          state_nxt = S_SLEEP;
        end
      end
      S_SLEEP: begin
        // no memory access is issued while asleep
        if (take) begin
          if (cmd_i.op == OP_WAKE) begin
            lp_n_nxt = 1'b1;
            sleeping_nxt = 1'b0;
            if (!shadow_r[CFG_SLEEP_BIT]) begin
              cnt_nxt = CNT_W'(DPD_INIT_CYCLES - 1);
              state_nxt = S_INIT;
            end else begin
              done_nxt = 1'b1;
              state_nxt = S_IDLE;
            end
          end else begin
            error_nxt = 1'b1;
          end
        end
      end
      S_INIT: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end else begin
          done_nxt = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    ready_nxt = (state_nxt == S_IDLE) || (state_nxt == S_SLEEP);
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
      step_r <= 2'h0;
      seq_wr_r <= 1'b0;
      word_r <= CFG_RESET;
      shadow_r <= CFG_RESET;
      sw_loaded_r <= 1'b0;
      sleeping_r <= 1'b0;
      lp_n_r <= 1'b1;
      ready_r <= 1'b0;
      done_r <= 1'b0;
      error_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
      seq_wr_r <= seq_wr_nxt;
      word_r <= word_nxt;
      shadow_r <= shadow_nxt;
      sw_loaded_r <= sw_loaded_nxt;
      sleeping_r <= sleeping_nxt;
      lp_n_r <= lp_n_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      error_r <= error_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // pin cycle engine
  // ------------------------------------------------------------
  pslp_access u_access (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .start_i(acc_start),
    .write_i(acc_write),
    .addr_i(acc_addr),
    .wdata_i(acc_wdata),
    .dq_i(dq_i),
    .ce_n_o(ce_n_o),
    .we_n_o(we_n_o),
    .oe_n_o(oe_n_o),
    .addr_o(addr_o),
    .dq_o(dq_o),
    .dq_oe_o(dq_oe_o),
    .rdata_o(acc_rdata),
    .done_o(acc_done)
  );

  assign cmd_ready_o = ready_r;
  assign done_o = done_r;
  assign error_o = error_r;
  assign rdata_o = rdata_r;
  assign cfg_shadow_o = shadow_r;
  assign sw_loaded_o = sw_loaded_r;
  assign sleeping_o = sleeping_r;
  assign lp_req_n_o = lp_n_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [9:0] lp_low_cnt_r;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      lp_low_cnt_r <= 10'h000;
    end else if (lp_n_r) begin
      lp_low_cnt_r <= 10'h000;
    end else if (lp_low_cnt_r != 10'h3ff) begin
      lp_low_cnt_r <= lp_low_cnt_r + 10'h001;
    end
  end

  sequence s_pin_write;
    !lp_req_n_o && we_n_o ##[1:20] !lp_req_n_o && !we_n_o;
  endsequence

  property p_pin_reserved;
    @(posedge clk_sys_i) disable iff (reset_i)
    (state_r == S_PWR && !we_n_o) |-> addr_o[19:8] == 12'h000 && !addr_o[3];
  endproperty
  a_pin_reserved: assert property (p_pin_reserved)
    else $error("reserved address bit set in pin load");

  property p_sw_reserved;
    @(posedge clk_sys_i) disable iff (reset_i)
    (state_r == S_SEQ && dq_oe_o) |-> dq_o[15:8] == 8'h00 && !dq_o[3];
  endproperty
  a_sw_reserved: assert property (p_sw_reserved)
    else $error("reserved data bit set in software load");

  property p_sw_no_deep;
    @(posedge clk_sys_i) disable iff (reset_i)
    (state_r == S_SEQ && seq_wr_r && dq_oe_o) |-> dq_o[CFG_SLEEP_BIT];
  endproperty
  a_sw_no_deep: assert property (p_sw_no_deep)
    else $error("software load selects deep sleep");

  property p_sw_addr;
    @(posedge clk_sys_i) disable iff (reset_i)
    (state_r == S_SEQ && !ce_n_o) |-> addr_o == CFG_TOP_ADDR;
  endproperty
  a_sw_addr: assert property (p_sw_addr)
    else $error("software access off the top address");

  property p_pin_write;
    @(posedge clk_sys_i) disable iff (reset_i)
    (state_r == S_IDLE && take && cmd_i.op == OP_PIN_LOAD && !temp_bad)
      |=> s_pin_write;
  endproperty
  a_pin_write: assert property (p_pin_write)
    else $error("pin load write not within window after request low");

  property p_hold;
    @(posedge clk_sys_i) disable iff (reset_i)
    $rose(sleeping_r) |-> lp_low_cnt_r >= 10'(ZZ_HOLD_CYC);
  endproperty
  a_hold: assert property (p_hold)
    else $error("sleep reported before minimum low time");

  property p_init;
    @(posedge clk_sys_i) disable iff (reset_i)
    (state_r == S_SLEEP && take && cmd_i.op == OP_WAKE &&
     !shadow_r[CFG_SLEEP_BIT]) |=> !cmd_ready_o[*8] ##0 ce_n_o;
  endproperty
  a_init: assert property (p_init)
    else $error("host ready too soon after deep sleep exit");

  property p_temp;
    @(posedge clk_sys_i) disable iff (reset_i)
    (state_r == S_IDLE && take && temp_bad &&
     cmd_i.op inside {OP_PIN_LOAD, OP_SW_WRITE}) |=> error_o && lp_req_n_o;
  endproperty
  a_temp: assert property (p_temp)
    else $error("too cool threshold not refused");

  property p_sleep_quiet;
    @(posedge clk_sys_i) disable iff (reset_i)
    sleeping_r |-> ce_n_o && !lp_req_n_o;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("access while asleep");
endmodule
`default_nettype wire

// >>> core/pslp_pkg.sv
// constants, types and helpers for the low-power memory configuration host
`default_nettype none
package pslp_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_WC_NS = 70;
  localparam int T_ZZWE_MIN_NS = 10;
  localparam int T_ZZ_MIN_US = 10;
  localparam int T_DPD_INIT_US = 150;
  localparam int ACC_CYC = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ZZWE_CYC =
    (T_ZZWE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // strictly longer than the minimum low time
  localparam int ZZ_HOLD_CYC = (T_ZZ_MIN_US * 1000) / CLK_PERIOD_NS + 1;
  localparam int DPD_INIT_CYC =
    (T_DPD_INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 2;
  localparam int CNT_W = 13;
  // ------------------------------------------------------------
  // pins and configuration word layout
  // ------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam logic [19:0] CFG_TOP_ADDR = 20'hfffff;
  localparam logic [19:0] CFG_RESET = 20'h00070;
  localparam int CFG_PAGE_BIT = 7;
  localparam int CFG_TEMP_LSB = 5;
  localparam int CFG_SLEEP_BIT = 4;
  localparam int CFG_COV_LSB = 0;
  localparam logic [1:0] TEMP_85 = 2'h3;
  localparam logic [1:0] TEMP_70 = 2'h0;
  localparam logic [1:0] TEMP_45 = 2'h1;
  localparam logic [1:0] TEMP_15 = 2'h2;
  localparam logic [2:0] COV_FULL = 3'h0;
  localparam logic [2:0] COV_NONE = 3'h4;

  typedef struct packed {
    logic page_en;
    logic [1:0] temp_sel;
    logic sleep_sel;
    logic [2:0] coverage;
  } pslp_cfg_t;

  typedef enum logic [2:0] {
    OP_PIN_LOAD = 3'h0,
    OP_SW_WRITE = 3'h1,
    OP_SW_READ = 3'h2,
    OP_SLEEP = 3'h3,
    OP_WAKE = 3'h4
  } pslp_op_t;

  typedef struct packed {
    pslp_op_t op;
    pslp_cfg_t cfg;
  } pslp_cmd_t;

  // builds the word with every reserved position at zero
  function automatic logic [19:0] pslp_pack(input pslp_cfg_t c);
    logic [19:0] w;
    w = 20'h00000;
    w[CFG_PAGE_BIT] = c.page_en;
    w[CFG_TEMP_LSB +: 2] = c.temp_sel;
    w[CFG_SLEEP_BIT] = c.sleep_sel;
    w[CFG_COV_LSB +: 3] = c.coverage;
    return w;
  endfunction

  // orders threshold codes from coolest to hottest
  function automatic logic [1:0] pslp_temp_rank(input logic [1:0] t);
    logic [1:0] r;
    r = 2'h3;
    case (t)
      TEMP_15: r = 2'h0;
      TEMP_45: r = 2'h1;
      TEMP_70: r = 2'h2;
      default: r = 2'h3;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

// >>> core/pslp_access.sv
// one asynchronous read or write cycle on the memory pins
`timescale 1ns/1ps
`default_nettype none
module pslp_access
  import pslp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic done_o
);
  typedef enum logic [1:0] {
    A_IDLE = 2'h0,
    A_ACT = 2'h1,
    A_SYNC = 2'h2,
    A_REC = 2'h3
  } pslp_acc_st_t;

  pslp_acc_st_t state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic ce_n_r, ce_n_nxt, we_n_r, we_n_nxt, oe_n_r, oe_n_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] dq_r, dq_nxt, rdata_r, rdata_nxt;
  logic dq_oe_r, dq_oe_nxt, done_r, done_nxt;
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r;

  // ------------------------------------------------------------
  // data bus synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
    end else begin
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    ce_n_nxt = ce_n_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    addr_nxt = addr_r;
    dq_nxt = dq_r;
    dq_oe_nxt = dq_oe_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    case (state_r)
      A_IDLE: begin
        if (start_i) begin
          wr_nxt = write_i;
          ce_n_nxt = 1'b0;
          we_n_nxt = ~write_i;
          oe_n_nxt = write_i;
          addr_nxt = addr_i;
          dq_nxt = wdata_i;
          dq_oe_nxt = write_i;
          cnt_nxt = 2'(ACC_CYC - 1);
          state_nxt = A_ACT;
        end
      end
      A_ACT: begin
        if (cnt_r != 2'h0) begin
          cnt_nxt = cnt_r - 2'h1;
        end else if (wr_r) begin
          // strobes rise together, data held one more cycle
          ce_n_nxt = 1'b1;
          we_n_nxt = 1'b1;
          state_nxt = A_REC;
        end else begin
          cnt_nxt = 2'(SYNC_CYC - 1);
          state_nxt = A_SYNC;
        end
      end
      A_SYNC: begin
        if (cnt_r != 2'h0) begin
          cnt_nxt = cnt_r - 2'h1;
        end else begin
          rdata_nxt = dq_s2_r;
          ce_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          state_nxt = A_REC;
        end
      end
      A_REC: begin
        dq_oe_nxt = 1'b0;
        done_nxt = 1'b1;
        state_nxt = A_IDLE;
      end
      default: state_nxt = A_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= A_IDLE;
      cnt_r <= 2'h0;
      wr_r <= 1'b0;
      ce_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      addr_r <= 20'h00000;
      dq_r <= 16'h0000;
      dq_oe_r <= 1'b0;
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      ce_n_r <= ce_n_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      addr_r <= addr_nxt;
      dq_r <= dq_nxt;
      dq_oe_r <= dq_oe_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
    end
  end

  assign ce_n_o = ce_n_r;
  assign we_n_o = we_n_r;
  assign oe_n_o = oe_n_r;
  assign addr_o = addr_r;
  assign dq_o = dq_r;
  assign dq_oe_o = dq_oe_r;
  assign rdata_o = rdata_r;
  assign done_o = done_r;
endmodule
`default_nettype wire

// >>> verif/pslp_mem_model.sv
// behavioural memory device that holds the configuration word
`timescale 1ns/1ps
`default_nettype none
module pslp_mem_model #(
  parameter int INIT_NS = 150000,
  parameter logic [15:0] ARRAY_WORD = 16'h5a3c
)
(
  input wire logic lp_req_n_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [19:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [19:0] cfg_o,
  output logic [1:0] mode_o,
  output logic init_busy_o,
  output logic [7:0] viol_o
);
  logic [19:0] cfg_r = 20'h00070;
  logic [1:0] mode_r = 2'h0;
  logic [1:0] step = 2'h0;
  logic [15:0] last = 16'h0000;
  logic [7:0] viol_r = 8'h00;
  logic armed = 1'h0, sw_used = 1'h0, pin_sleep = 1'h0, busy = 1'h0;
  logic wr = 1'h0, rd, full_refresh;
  realtime t_fall = 0.0;
  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  assign cfg_o = cfg_r;
  assign mode_o = mode_r;
  assign init_busy_o = busy;
  assign viol_o = viol_r;
  assign full_refresh = cfg_r[2:0] != 3'h4;
  assign rd = !ce_n_i && !oe_n_i && lp_req_n_i && mode_r == 2'h0;
  assign dq_o = rd ? (step == 2'h3 ? cfg_r[15:0] : ARRAY_WORD) : ~last;
  always @(negedge we_n_i) wr = 1'h1;
  always @(negedge ce_n_i) if (busy) viol_r = viol_r + 8'h01;
  always @(negedge lp_req_n_i) begin
    armed = 1'h1;
    t_fall = $realtime;
  end
  // pin load takes the address lines on the first rising strobe
  always @(posedge ce_n_i or posedge we_n_i) begin
    if (armed && !lp_req_n_i && mode_r == 2'h0) begin
      if (addr_i[19:8] != 12'h000 || addr_i[3]) begin
        viol_r = viol_r + 8'h01;
      end
      cfg_r = addr_i;
      armed = 1'h0;
    end
  end
  // software sequence: read, read, write, then write or read at the top
  always @(posedge ce_n_i) begin
    if (lp_req_n_i && mode_r == 2'h0) begin
      if (!wr) last = step == 2'h3 ? cfg_r[15:0] : ARRAY_WORD;
      if (addr_i != 20'hfffff) step = 2'h0;
      else if (step < 2'h2) step = wr ? 2'h0 : step + 2'h1;
      else if (step == 2'h2) step = wr ? 2'h3 : 2'h0;
      else begin
        step = 2'h0;
        if (wr) begin
          if (!dq_i[4]) viol_r = viol_r + 8'h01;
          cfg_r[15:0] = dq_i;
          sw_used = 1'h1;
          if (dq_i[4]) mode_r = 2'h1;
        end
      end
    end
    wr = 1'h0;
  end
  always #5 begin
    if (!lp_req_n_i && !pin_sleep && $realtime - t_fall > 10000.0) begin
      pin_sleep = 1'h1;
      armed = 1'h0;
      if (!cfg_r[4]) mode_r = 2'h2;
      else if (!sw_used) mode_r = 2'h1;
    end
  end
  always @(posedge lp_req_n_i) begin
    armed = 1'h0;
    if (pin_sleep) begin
      pin_sleep = 1'h0;
      busy = mode_r == 2'h2;
      mode_r = 2'h0;
      #(INIT_NS);
      busy = 1'h0;
    end
  end
endmodule
`default_nettype wire

// >>> verif/pslp_host_bench.sv
// self-checking bench for the low-power configuration host
`timescale 1ns/1ps
`default_nettype none
module pslp_host_bench
  import pslp_pkg::*;
;
  localparam int INIT_CYC = 20;
  logic clk_sys_i = 1'h0, reset_i = 1'h1, cmd_valid_i = 1'h0;
  pslp_cmd_t cmd_i = '0;
  logic [1:0] temp_floor_i = TEMP_15;
  logic cmd_ready_o, done_o, error_o, sw_loaded_o, sleeping_o, lp_req_n_o;
  logic ce_n_o, we_n_o, oe_n_o, dq_oe_o, init_busy;
  logic [15:0] rdata_o, dq_o, mem_dq, dq_bus;
  logic [19:0] cfg_shadow_o, addr_o, mem_cfg;
  logic [1:0] mode;
  logic [7:0] viol;
  logic [1:0] q[$];
  integer mismatches = 0, checks_done = 0, cyc = 0;
  int seed = 32'hffd3;
  always #12.5 clk_sys_i = ~clk_sys_i;
  assign dq_bus = dq_oe_o ? dq_o : mem_dq;
  pslp_host #(.DPD_INIT_CYCLES(INIT_CYC)) uut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .temp_floor_i(temp_floor_i), .dq_i(dq_bus),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .error_o(error_o),
    .rdata_o(rdata_o), .cfg_shadow_o(cfg_shadow_o),
    .sw_loaded_o(sw_loaded_o), .sleeping_o(sleeping_o),
    .lp_req_n_o(lp_req_n_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
    .oe_n_o(oe_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o)
  );
  pslp_mem_model #(.INIT_NS(INIT_CYC * CLK_PERIOD_NS)) mem (
    .lp_req_n_i(lp_req_n_o), .ce_n_i(ce_n_o), .we_n_i(we_n_o),
    .oe_n_i(oe_n_o), .addr_i(addr_o), .dq_i(dq_bus), .dq_o(mem_dq),
    .cfg_o(mem_cfg), .mode_o(mode), .init_busy_o(init_busy),
    .viol_o(viol)
  );
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp2(input string n, input logic [1:0] e,
                      input logic [1:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic cmp20(input string n, input logic [19:0] e,
                       input logic [19:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  function automatic pslp_cfg_t mk(input logic p, input logic [1:0] t,
                                   input logic s, input logic [2:0] c);
    return '{p, t, s, c};
  endfunction
  function automatic logic [19:0] word(input pslp_cfg_t c);
    return {12'h000, c.page_en, c.temp_sel, c.sleep_sel, 1'h0, c.coverage};
  endfunction
  task automatic send(input pslp_op_t op, input pslp_cfg_t c, input logic err);
    @(negedge clk_sys_i);
    while (cmd_ready_o !== 1'h1) @(negedge clk_sys_i);
    cmd_i.op = op;
    cmd_i.cfg = c;
    cmd_valid_i = 1'h1;
    q.push_back({err, ~err});
    @(negedge clk_sys_i);
    cmd_valid_i = 1'h0;
    while (q.size() != 0) @(negedge clk_sys_i);
  endtask
  // ------------------------------------------------------------
  // result watcher and timeout
  // ------------------------------------------------------------
  always @(negedge clk_sys_i) begin
    if (done_o === 1'h1 || error_o === 1'h1) begin
      if (q.size() == 0) begin
        cmp2("unasked result", 2'h0, {error_o, done_o});
      end else begin
        cmp2("status", q.pop_front(), {error_o, done_o});
      end
    end
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    pslp_cfg_t c;
    logic [31:0] r;
    integer i;
    repeat (12) @(negedge clk_sys_i);
    reset_i = 1'h0;
    repeat (2) @(negedge clk_sys_i);
    cmp20("shadow reset", 20'h00070, cfg_shadow_o);
    cmp20("device reset", 20'h00070, mem_cfg);
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      c = mk(r[0], i[1:0], 1'h1, r[3:1]);
      send(OP_PIN_LOAD, c, 1'h0);
      cmp20("pin load", word(c), mem_cfg);
      cmp20("shadow", word(c), cfg_shadow_o);
      send(OP_SW_READ, c, 1'h0);
      cmp20("readback", word(c), {4'h0, rdata_o});
    end
    send(OP_SLEEP, c, 1'h0);
    cmp2("partial", 2'h1, mode);
    cmp2("sleeping", 2'h1, {1'h0, sleeping_o});
    send(OP_PIN_LOAD, c, 1'h1);
    send(OP_WAKE, c, 1'h0);
    cmp2("awake", 2'h0, mode);
    send(OP_WAKE, c, 1'h0);
    temp_floor_i = TEMP_85;
    send(OP_PIN_LOAD, mk(1'h0, TEMP_70, 1'h1, 3'h0), 1'h1);
    send(OP_SW_WRITE, mk(1'h0, TEMP_45, 1'h1, 3'h0), 1'h1);
    temp_floor_i = TEMP_15;
    cmp20("refused load", word(c), mem_cfg);
    send(OP_SW_WRITE, mk(1'h0, TEMP_85, 1'h0, 3'h0), 1'h1);
    c = mk(1'h0, TEMP_85, 1'h0, COV_NONE);
    send(OP_PIN_LOAD, c, 1'h0);
    send(OP_SLEEP, c, 1'h0);
    cmp2("deep", 2'h2, mode);
    send(OP_WAKE, c, 1'h0);
    cmp2("recovered", 2'h0, {1'h0, init_busy});
    cmp2("ready", 2'h1, {1'h0, cmd_ready_o});
    c = mk(1'h1, TEMP_70, 1'h1, 3'h5);
    send(OP_SW_WRITE, c, 1'h0);
    cmp20("soft load", word(c), mem_cfg);
    cmp20("soft shadow", word(c), cfg_shadow_o);
    cmp2("soft partial", 2'h1, mode);
    cmp2("soft flag", 2'h1, {1'h0, sw_loaded_o});
    cmp20("violations", 20'h00000, {12'h000, viol});
    complete_run();
  end
endmodule
`default_nettype wire
